//--- shift_reg_defs.vh
// Offsets, field positions, reset values and option codes of the shift register
`ifndef SHIFT_REG_DEFS_VH
`define SHIFT_REG_DEFS_VH

`define SR_WIDTH_SYNC        4
`define SR_WIDTH_ASYNC       8
`define SR_MAX_WIDTH         8

`define SR_ADDR_W            5
`define SR_OFF_CTRL          5'h00
`define SR_OFF_LOAD_DATA     5'h04
`define SR_OFF_COMMAND       5'h08
`define SR_OFF_STATUS        5'h0C
`define SR_OFF_OPTIONS       5'h10

`define SR_CTRL_SW_MODE      0
`define SR_CTRL_LEFT         1
`define SR_CTRL_LEFT_IN      2
`define SR_CTRL_RIGHT_IN     3
`define SR_CTRL_INIT         4

`define SR_CMD_SHIFT         0
`define SR_CMD_LOAD          1
`define SR_CMD_RESET         2

`define SR_OPT_SYNC          8
`define SR_OPT_LOAD          9
`define SR_OPT_BIDIR         10

`define SR_CTRL_RESET        4'h2
`define SR_DATA_RESET        8'h00
`define SR_BUS_ZERO          32'h0000_0000

`endif

//--- shift_stage_core.v
// Shift register datapath: clear, load and left or right shift per bit
`timescale 1ns/1ps
module shift_stage_core #(
    parameter WIDTH      = 4,
    parameter SYNC_RESET = 1,
    parameter HAS_LOAD   = 1,
    parameter BIDIR      = 1
) (
    input  wire             clk_sys,
    input  wire             init_clear,
    input  wire             async_zero,
    input  wire             sync_reset,
    input  wire             load,
    input  wire             clk_en,
    input  wire             shift_left,
    input  wire             shift_left_serial_in,
    input  wire             shift_right_serial_in,
    input  wire [WIDTH-1:0] par_data,
    output reg  [WIDTH-1:0] q
);

    wire [WIDTH-1:0] shifted;
    reg  [WIDTH-1:0] next_q;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1)
        begin : g_bit
            wire from_low;
            wire from_high;
            if (i == 0)
            begin : g_first
                assign from_low = shift_left_serial_in;
            end
            else
            begin : g_mid_low
                assign from_low = q[i-1];
            end
            if (i == WIDTH - 1)
            begin : g_last
                assign from_high = shift_right_serial_in;
            end
            else
            begin : g_mid_high
                assign from_high = q[i+1];
            end
            // Without the bidirectional option the direction input is ignored
            assign shifted[i] = (BIDIR != 0 && !shift_left) ? from_high : from_low;
        end
    endgenerate

    always @*
    begin
        next_q = q;
        if (init_clear)
            next_q = {WIDTH{1'b0}};
        else if (SYNC_RESET != 0 && sync_reset)
            next_q = {WIDTH{1'b0}};
        else if (HAS_LOAD != 0 && load)
            next_q = par_data;
        else if (clk_en)
            next_q = shifted;
        // Otherwise hold: enable and load both low
    end

    generate
        if (SYNC_RESET != 0)
        begin : g_sync
            always @(posedge clk_sys)
            begin
                q <= next_q;
            end
        end
        else
        begin : g_async
            // Clear acts without a clock edge and beats everything else
            always @(posedge clk_sys or posedge async_zero)
            begin
                if (async_zero)
                    q <= {WIDTH{1'b0}};
                else
                    q <= next_q;
            end
        end
    endgenerate

endmodule

//--- loadable_bidir_shift_register.v
// Configurable shift register family with an Avalon-MM control and status port
//
// How it works
// - Synchronous reset clears all bits, above load and shift, below init.
// - Left shift puts left serial input into bit 0.
// - Left shift moves each bit one place up.
// - Enable low stops shifting; load, reset and init still act.
// - Load copies parallel data regardless of enable.
// - Load and enable both low hold contents.
// - Shift only with enable, no load, no reset.
// - Direction high shifts toward higher bits.
// - Direction low shifts down, right input at top.
// - Asynchronous clear zeroes bits without clock.
// - Every variant starts with all bits low.
// - Global init clears like power-up, active high.
// - Four bits synchronous, eight bits asynchronous variant.
`timescale 1ns/1ps
`include "shift_reg_defs.vh"
module loadable_bidir_shift_register #(
    parameter SYNC_RESET = 1,
    parameter HAS_LOAD   = 1,
    parameter BIDIR      = 1
) (
    input  wire                   clk_sys,
    input  wire                   sys_rst,
    input  wire                   global_init,
    input  wire                   async_zero,
    input  wire                   sync_reset,
    input  wire                   load,
    input  wire                   clk_en,
    input  wire                   shift_left,
    input  wire                   shift_left_serial_in,
    input  wire                   shift_right_serial_in,
    input  wire [`SR_MAX_WIDTH-1:0] par_data,
    output wire [`SR_MAX_WIDTH-1:0] q,
    input  wire [`SR_ADDR_W-1:0]  avs_address,
    input  wire                   avs_read,
    input  wire                   avs_write,
    input  wire [31:0]            avs_writedata,
    input  wire [3:0]             avs_byteenable,
    output reg  [31:0]            avs_readdata,
    output reg                    avs_waitrequest
);

    // Width follows the reset style
    localparam WIDTH = (SYNC_RESET != 0) ? `SR_WIDTH_SYNC : `SR_WIDTH_ASYNC;

    reg  [3:0]       ctrl;
    reg  [WIDTH-1:0] sw_data;
    reg              cmd_shift;
    reg              cmd_load;
    reg              cmd_reset;
    reg              soft_init;
    wire [WIDTH-1:0] core_q;

    wire sw_mode  = ctrl[`SR_CTRL_SW_MODE];
    wire take_wr  = avs_write && !avs_waitrequest;
    wire lane0    = avs_byteenable[0];

    // Controls come either from the pins or from the software registers
    wire             eff_reset = sw_mode ? cmd_reset : sync_reset;
    wire             eff_load  = sw_mode ? cmd_load : load;
    wire             eff_en    = sw_mode ? cmd_shift : clk_en;
    wire             eff_left  = sw_mode ? ctrl[`SR_CTRL_LEFT] : shift_left;
    wire             eff_left_in  = sw_mode ? ctrl[`SR_CTRL_LEFT_IN] : shift_left_serial_in;
    wire             eff_right_in = sw_mode ? ctrl[`SR_CTRL_RIGHT_IN] : shift_right_serial_in;
    wire [WIDTH-1:0] eff_data  = sw_mode ? sw_data : par_data[WIDTH-1:0];

    // Power-up, global init and the software init pulse all clear alike
    wire init_clear = sys_rst | global_init | soft_init;

    // Reset value kept at full width, cut to the active width on use
    wire [`SR_MAX_WIDTH-1:0] data_reset = `SR_DATA_RESET;

    shift_stage_core #(
        .WIDTH      (WIDTH),
        .SYNC_RESET (SYNC_RESET),
        .HAS_LOAD   (HAS_LOAD),
        .BIDIR      (BIDIR)
    ) shift_stage_core_i (
        .clk_sys               (clk_sys),
        .init_clear            (init_clear),
        .async_zero            (async_zero),
        .sync_reset            (eff_reset),
        .load                  (eff_load),
        .clk_en                (eff_en),
        .shift_left            (eff_left),
        .shift_left_serial_in  (eff_left_in),
        .shift_right_serial_in (eff_right_in),
        .par_data              (eff_data),
        .q                     (core_q)
    );

    generate
        if (WIDTH < `SR_MAX_WIDTH)
        begin : g_pad
            assign q = {{(`SR_MAX_WIDTH - WIDTH){1'b0}}, core_q};
        end
        else
        begin : g_full
            assign q = core_q;
        end
    endgenerate

    // Every request is answered one cycle after it is first seen
    always @(posedge clk_sys)
    begin
        if (sys_rst)
            avs_waitrequest <= 1'b1;
        else
            avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
    end

    always @(posedge clk_sys)
    begin
        if (sys_rst)
            avs_readdata <= `SR_BUS_ZERO;
        else if (avs_read && avs_waitrequest)
        begin
            avs_readdata <= `SR_BUS_ZERO;
            case (avs_address)
                `SR_OFF_CTRL:
                    avs_readdata[3:0] <= ctrl;
                `SR_OFF_LOAD_DATA:
                    avs_readdata[WIDTH-1:0] <= sw_data;
                `SR_OFF_STATUS:
                    avs_readdata[WIDTH-1:0] <= core_q;
                `SR_OFF_OPTIONS:
                begin
                    avs_readdata[7:0] <= WIDTH[7:0];
                    avs_readdata[`SR_OPT_SYNC] <= (SYNC_RESET != 0);
                    avs_readdata[`SR_OPT_LOAD] <= (HAS_LOAD != 0);
                    avs_readdata[`SR_OPT_BIDIR] <= (BIDIR != 0);
                end
                default:
                    avs_readdata <= `SR_BUS_ZERO;
            endcase
        end
    end

    // Command bits are one-cycle pulses; a stale one must not repeat a shift
    always @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            ctrl      <= `SR_CTRL_RESET;
            sw_data   <= data_reset[WIDTH-1:0];
            cmd_shift <= 1'b0;
            cmd_load  <= 1'b0;
            cmd_reset <= 1'b0;
            soft_init <= 1'b0;
        end
        else
        begin
            cmd_shift <= 1'b0;
            cmd_load  <= 1'b0;
            cmd_reset <= 1'b0;
            soft_init <= 1'b0;
            if (take_wr && lane0)
            begin
                case (avs_address)
                    `SR_OFF_CTRL:
                    begin
                        ctrl      <= avs_writedata[3:0];
                        soft_init <= avs_writedata[`SR_CTRL_INIT];
                    end
                    `SR_OFF_LOAD_DATA:
                        sw_data <= avs_writedata[WIDTH-1:0];
                    `SR_OFF_COMMAND:
                    begin
                        cmd_shift <= avs_writedata[`SR_CMD_SHIFT];
                        cmd_load  <= avs_writedata[`SR_CMD_LOAD];
                        cmd_reset <= avs_writedata[`SR_CMD_RESET];
                    end
                    default:
                        ctrl <= ctrl;
                endcase
            end
        end
    end

endmodule

//--- shift_reg_checks_assertions.sv
// Concurrent checks on the shift register pins and bus handshake
`timescale 1ns/1ps
`include "shift_reg_defs.vh"
module shift_reg_checks (
    input wire                     clk_sys,
    input wire                     sys_rst,
    input wire                     global_init,
    input wire                     sync_reset,
    input wire                     load,
    input wire                     clk_en,
    input wire                     shift_left,
    input wire                     shift_left_serial_in,
    input wire                     shift_right_serial_in,
    input wire [`SR_MAX_WIDTH-1:0] par_data,
    input wire [`SR_MAX_WIDTH-1:0] q,
    input wire                     avs_read,
    input wire                     avs_write,
    input wire [`SR_ADDR_W-1:0]    avs_address,
    input wire [31:0]              avs_writedata,
    input wire [3:0]               avs_byteenable,
    input wire                     avs_waitrequest
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    reg pin_mode;
    // Software mode ignores the pins except global init and async clear, so the other pin checks pause while it is on
    always @(posedge clk_sys)
    begin
        if (sys_rst)
            pin_mode <= 1'b1;
        else if (avs_write && !avs_waitrequest && avs_byteenable[0]
                 && avs_address == `SR_OFF_CTRL)
            pin_mode <= !avs_writedata[`SR_CTRL_SW_MODE];
    end
    wire quiet = pin_mode && !global_init && !sync_reset;
    wire shifting = quiet && !load && clk_en;
    sequence s_answer;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence
    a_sync_clear: assert property (pin_mode && sync_reset |=> q == 8'h00)
        else $error("q not cleared by sync reset");
    a_init_clear: assert property (global_init |=> q == 8'h00)
        else $error("q not cleared by global init");
    a_load_copy: assert property (quiet && load |=> q[3:0] == $past(par_data[3:0]))
        else $error("parallel load wrong");
    a_left_move: assert property (shifting && shift_left |=>
        q[3:0] == {$past(q[2:0]), $past(shift_left_serial_in)})
        else $error("left shift wrong");
    a_right_move: assert property (shifting && !shift_left |=>
        q[3:0] == {$past(shift_right_serial_in), $past(q[3:1])})
        else $error("right shift wrong");
    a_idle_hold: assert property (quiet && !load && !clk_en |=> $stable(q))
        else $error("q changed while idle");
    a_upper_zero: assert property (q[7:4] == 4'h0)
        else $error("unused q bits not zero");
    a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> s_answer)
        else $error("bus answer not one cycle");
endmodule
bind loadable_bidir_shift_register shift_reg_checks shift_reg_checks_i (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .global_init(global_init),
    .sync_reset(sync_reset), .load(load), .clk_en(clk_en), .shift_left(shift_left),
    .shift_left_serial_in(shift_left_serial_in), .par_data(par_data), .q(q),
    .shift_right_serial_in(shift_right_serial_in), .avs_read(avs_read),
    .avs_write(avs_write), .avs_address(avs_address), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_waitrequest(avs_waitrequest));

//--- upstream_stage.sv
// Upstream cascade stage feeding the register's left serial input
`timescale 1ns/1ps
module upstream_stage (
    input  wire clk_sys,
    input  wire clear,
    input  wire shift_en,
    input  wire serial_in,
    output wire top_bit
);
    reg [3:0] stage;
    // Shares clock, shift enable and clear with the stage it feeds; has no parallel load
    always @(posedge clk_sys)
    begin
        if (clear)
            stage <= 4'h0;
        else if (shift_en)
            stage <= {stage[2:0], serial_in};
    end
    assign top_bit = stage[3];
endmodule

//--- loadable_bidir_shift_register_test.sv
// Self-checking bench for the shift register family
`timescale 1ns/1ps
`include "shift_reg_defs.vh"
module loadable_bidir_shift_register_test;
    reg        clk_sys = 1'b0;
    reg        sys_rst, global_init, sync_reset, load, clk_en, shift_left;
    reg        left_in_tb, right_in, casc, din, avs_read, avs_write;
    reg [7:0]  par_data, q_seen;
    reg [4:0]  avs_address;
    reg [31:0] avs_writedata, rd;
    wire [7:0] q;
    wire [31:0] avs_readdata;
    wire       avs_waitrequest, top_bit;
    integer    err_total = 0, checks_done = 0, i;
    always #5 clk_sys = ~clk_sys;
    upstream_stage upstream_stage_i (.clk_sys(clk_sys), .top_bit(top_bit),
        .clear(sys_rst | sync_reset | global_init), .shift_en(clk_en & ~load), .serial_in(din));
    loadable_bidir_shift_register loadable_bidir_shift_register_i (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .global_init(global_init), .async_zero(1'b0),
        .sync_reset(sync_reset), .load(load), .clk_en(clk_en), .shift_left(shift_left),
        .shift_left_serial_in(casc ? top_bit : left_in_tb), .shift_right_serial_in(right_in),
        .par_data(par_data), .q(q), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
    task results;
    begin
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    end
    endtask
    task chk(input [8*8-1:0] name, input [31:0] exp, input [31:0] got);
    begin
        checks_done = checks_done + 1;
        if (got !== exp)
        begin
            err_total = err_total + 1;
            $display("mismatch %0s expected %h seen %h", name, exp, got);
        end
    end
    endtask
    // One transfer; ends one edge after release so back-to-back calls never collide
    task bus(input wr, input [4:0] a, input [31:0] wd);
        integer n;
    begin
        avs_write <= wr;
        avs_read <= !wr;
        avs_address <= a;
        avs_writedata <= wd;
        n = 0;
        do
        begin
            @(posedge clk_sys);
            n = n + 1;
        end
        while (avs_waitrequest !== 1'b0 && n < 20);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (avs_waitrequest !== 1'b0)
        begin
            err_total = err_total + 1;
            results();
        end
        @(posedge clk_sys);
    end
    endtask
    // Applies controls for one edge, then an idle edge that must hold q
    task step(input rs, input ld, input en, input lf, input sl, input sr, input [7:0] d);
    begin
        sync_reset <= rs;
        load <= ld;
        clk_en <= en;
        shift_left <= lf;
        left_in_tb <= sl;
        right_in <= sr;
        par_data <= d;
        @(posedge clk_sys);
        sync_reset <= 1'b0;
        load <= 1'b0;
        clk_en <= 1'b0;
        @(negedge clk_sys);
        q_seen = q;
        @(posedge clk_sys);
    end
    endtask
    initial
    begin
        sys_rst = 1'b1;
        {global_init, sync_reset, load, clk_en, shift_left, left_in_tb, right_in, casc, din} = 9'h000;
        {avs_read, avs_write, avs_address, avs_writedata, par_data} = 47'h0;
        repeat (16) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(posedge clk_sys);
        bus(1'b0, `SR_OFF_STATUS, 32'h0);
        chk("status", 32'h0000_0000, rd);
        bus(1'b0, `SR_OFF_OPTIONS, 32'h0);
        chk("options", 32'h0000_0704, rd);
        bus(1'b0, `SR_OFF_CTRL, 32'h0);
        chk("ctrl", 32'h0000_0002, rd);
        bus(1'b1, `SR_OFF_LOAD_DATA, 32'h0000_0005);
        bus(1'b0, `SR_OFF_LOAD_DATA, 32'h0);
        chk("ldata", 32'h0000_0005, rd);
        bus(1'b1, 5'h14, 32'h0000_00FF);
        bus(1'b0, 5'h14, 32'h0);
        chk("unmapped", 32'h0000_0000, rd);
        step(1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 8'h0A);
        chk("load", 32'h0000_000A, q_seen);
        step(1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 8'h05);
        chk("hold", 32'h0000_000A, q_seen);
        step(1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 8'h00);
        chk("left", 32'h0000_0005, q_seen);
        step(1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 8'h00);
        chk("right", 32'h0000_000A, q_seen);
        step(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 8'h0F);
        chk("sreset", 32'h0000_0000, q_seen);
        global_init <= 1'b1;
        step(1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 8'h03);
        global_init <= 1'b0;
        chk("init", 32'h0000_0000, q_seen);
        casc <= 1'b1;
        for (i = 0; i < 8; i = i + 1)
        begin
            din <= (i == 0 || i == 1 || i == 3);
            step(1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 8'h00);
        end
        chk("cascade", 32'h0000_000D, q_seen);
        bus(1'b0, `SR_OFF_STATUS, 32'h0);
        chk("status", 32'h0000_000D, rd);
        // Software mode: init pulse, then load, shifts and reset by command
        bus(1'b1, `SR_OFF_CTRL, 32'h0000_0013);
        bus(1'b0, `SR_OFF_CTRL, 32'h0);
        chk("swctrl", 32'h0000_0003, rd);
        bus(1'b0, `SR_OFF_STATUS, 32'h0);
        chk("swinit", 32'h0000_0000, rd);
        bus(1'b1, `SR_OFF_COMMAND, 32'h0000_0002);
        bus(1'b0, `SR_OFF_STATUS, 32'h0);
        chk("swload", 32'h0000_0005, rd);
        step(1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 8'h0F);
        chk("pinsoff", 32'h0000_0005, q_seen);
        bus(1'b1, `SR_OFF_CTRL, 32'h0000_0007);
        bus(1'b1, `SR_OFF_COMMAND, 32'h0000_0001);
        bus(1'b0, `SR_OFF_STATUS, 32'h0);
        chk("swleft", 32'h0000_000B, rd);
        bus(1'b1, `SR_OFF_CTRL, 32'h0000_0009);
        bus(1'b1, `SR_OFF_COMMAND, 32'h0000_0001);
        bus(1'b0, `SR_OFF_STATUS, 32'h0);
        chk("swright", 32'h0000_000D, rd);
        bus(1'b1, `SR_OFF_COMMAND, 32'h0000_0004);
        bus(1'b0, `SR_OFF_STATUS, 32'h0);
        chk("swreset", 32'h0000_0000, rd);
        results();
    end
endmodule
